/* File: rsac_pkg.sv */
// Shared constants for the resolver setup and alignment command path
package rsac_pkg;
    localparam int          NWORDS        = 10;
    localparam logic [15:0] CMD_FOREIGN   = 16'hB004;
    localparam logic [15:0] CMD_SAVE_EXIT = 16'h800E;
    localparam logic [15:0] CMD_ABANDON   = 16'h800F;
    localparam logic [15:0] CMD_ALIGN_IN  = 16'h9000;
    localparam logic [15:0] CMD_SETUP_IN  = 16'hB000;
    localparam logic [15:0] ALIGN_PASSWD  = 16'h1298;
    localparam logic [15:0] SETUP_RSVD    = 16'hFEFC;
    localparam int          STROBE_BIT    = 15;
    localparam int          GEAR_BIT      = 8;
    localparam int          LATCH_BIT     = 1;
    localparam int          DIR_BIT       = 0;
    localparam logic [15:0] TYPE_MIN      = 16'h0002;
    localparam logic [15:0] TYPE_MAX      = 16'h0080;
    localparam logic [31:0] FSC_MIN       = 32'h0000_0002;
    localparam logic [3:0]  ERR_NONE      = 4'h0;
    localparam logic [3:0]  ERR_CMD       = 4'h1;
    // Module status word bits
    localparam int          ST_ACK_BIT    = 15;
    localparam int          ST_ALIGN_BIT  = 14;
    localparam int          ST_SETUP_BIT  = 13;
    localparam int          ST_INIT_BIT   = 12;
    localparam int          ST_FAULT_BIT  = 11;
    localparam int          ST_GEAR_BIT   = 6;
    localparam int          ST_LATCH_BIT  = 5;
    localparam int          ST_DIR_BIT    = 4;
    // Host register offsets (Wishbone, byte addresses)
    localparam logic [7:0]  HR_CTRL       = 8'h00;
    localparam logic [7:0]  HR_STATUS     = 8'h04;
    localparam logic [7:0]  HR_RESP       = 8'h08;
    localparam logic [7:0]  HR_WORD0      = 8'h40;
    localparam logic [15:0] ZERO16        = 16'h0000;
    typedef enum logic [1:0] {
        RSAC_MEAS,
        RSAC_SETUP,
        RSAC_ALIGN
    } rsac_mode_t;
endpackage

/* File: rsac_if.sv */
// Network link between host controller and resolver module
`timescale 1ns/1ps
interface rsac_if;
    logic [15:0] out_word [0:9];   // Host to device
    logic [15:0] in_word  [0:9];   // Device to host
    modport dev  (input out_word, output in_word);
    modport host (output out_word, input in_word);
endinterface

/* File: rsac_dev.sv */
// Resolver module command interpreter for setup and alignment commands
// What this block does
// - Foreign dual setup: B004, setup, type, turns
// - Host gives turns dividing transducer type
// - Host keeps full scale and preset in range
// - Host zeroes reserved setup word bits
// - Bit 8 gearing only for foreign dual
// - Bit 1 latches fault until host clears; in alignment the fault flag self clears
// - Bit 0 selects counting sense
// - Edits apply only on exit; reset discards
// - 800E saves, acknowledges, leaves setup
// - After save foreign dual enters alignment
// - 800F acknowledges, discards, enters measurement
// - Word 0 bit 15 is command strobe
// - Command taken only on strobe rise
// - Strobe clear clears acknowledge flag
// - Alignment entry needs initialized configuration
// - Enter alignment: 9000, password 1298, zeros
// - Accept sets ack and alignment flag
// - Error code in status bits three to zero
// - Two-word values: low word first
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module rsac_dev
    import rsac_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    rsac_if.dev             net,
    input  wire logic       fault_raw_i,
    input  wire logic       fault_clr_i,
    input  wire logic       cfg_valid_i,
    output logic            saving_o,
    output logic [15:0]     mode_o,
    output logic [31:0]     fsc_o,
    output logic [31:0]     preset_o
);
    rsac_mode_t  mode_q;
    logic        strobe_q;
    logic        ack_q;
    logic [3:0]  err_q;
    logic        init_q;
    logic        fault_q;
    logic [15:0] pend_setup_q, sav_setup_q;
    logic [15:0] pend_type_q, sav_type_q;
    logic [15:0] pend_turns_q, sav_turns_q;
    logic [31:0] pend_fsc_q, sav_fsc_q;
    logic [31:0] pend_pre_q, sav_pre_q;
    logic        pend_foreign_q, sav_foreign_q;
    logic        save_q;

    logic [15:0] w0;
    logic        cmd_rise;
    logic [31:0] fsc_w, pre_w;
    logic [47:0] fsc_lim;
    logic        tail_zero;
    logic        rest_zero;
    logic        save_go;
    logic        setup_ok;
    logic        align_ok;
    logic        valid_cmd;

    assign w0       = net.out_word[0];
    assign cmd_rise = w0[STROBE_BIT] && !strobe_q;
    assign fsc_w    = {net.out_word[5], net.out_word[4]};
    assign pre_w    = {net.out_word[7], net.out_word[6]};
    assign fsc_lim  = {16'h0000, net.out_word[3], 16'h0000}; // 65536 x turns

    // Words 2..9 all zero; exit commands also need word 1 zero
    always_comb begin
        rest_zero = 1'b1;
        for (int i = 2; i < NWORDS; i++) begin
            if (net.out_word[i] != ZERO16) begin
                rest_zero = 1'b0;
            end
        end
    end
    assign tail_zero = rest_zero && (net.out_word[1] == ZERO16);

    // Save lands on the acknowledging edge so status stays consistent
    assign save_go = cmd_rise && (w0 == CMD_SAVE_EXIT)
                     && (mode_q == RSAC_SETUP) && tail_zero;

    // Foreign dual setup range checks
    always_comb begin
        setup_ok = (mode_q == RSAC_SETUP)
            && ((net.out_word[1] & SETUP_RSVD) == ZERO16)
            && (net.out_word[2] >= TYPE_MIN)
            && (net.out_word[2] <= TYPE_MAX)
            && (net.out_word[3] != ZERO16)
            && (net.out_word[3] <= net.out_word[2])
            && ((net.out_word[2] % net.out_word[3]) == ZERO16)
            && (fsc_w >= FSC_MIN)
            && ({16'h0000, fsc_w} <= fsc_lim)
            && (pre_w < fsc_w)
            && (net.out_word[8] == ZERO16)
            && (net.out_word[9] == ZERO16);
    end

    // Alignment entry guard
    assign align_ok = (net.out_word[1] == ALIGN_PASSWD) && init_q;

    // Strobe history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= w0[STROBE_BIT];
        end
    end

    // Initialized flag captured after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_q <= 1'b0;
        end else begin
            init_q <= cfg_valid_i || init_q;
        end
    end

    // Command decode, acknowledge and error code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q  <= RSAC_MEAS;
            ack_q   <= 1'b0;
            err_q   <= ERR_NONE;
            save_q  <= 1'b0;
            pend_setup_q   <= ZERO16;
            pend_type_q    <= ZERO16;
            pend_turns_q   <= ZERO16;
            pend_fsc_q     <= 32'h0000_0000;
            pend_pre_q     <= 32'h0000_0000;
            pend_foreign_q <= 1'b0;
        end else begin
            save_q <= 1'b0;
            if (!w0[STROBE_BIT]) begin
                ack_q <= 1'b0;
            end else if (cmd_rise) begin
                ack_q <= 1'b1;
                err_q <= ERR_NONE;
                case (w0)
                    CMD_FOREIGN: begin
                        if (setup_ok) begin
                            pend_setup_q   <= net.out_word[1];
                            pend_type_q    <= net.out_word[2];
                            pend_turns_q   <= net.out_word[3];
                            pend_fsc_q     <= fsc_w;
                            pend_pre_q     <= pre_w;
                            pend_foreign_q <= 1'b1;
                        end else begin
                            err_q <= ERR_CMD;
                        end
                    end
                    CMD_SETUP_IN: begin
                        if (align_ok && rest_zero) begin
                            mode_q <= RSAC_SETUP;
                            pend_setup_q   <= sav_setup_q;
                            pend_type_q    <= sav_type_q;
                            pend_turns_q   <= sav_turns_q;
                            pend_fsc_q     <= sav_fsc_q;
                            pend_pre_q     <= sav_pre_q;
                            pend_foreign_q <= sav_foreign_q;
                        end else begin
                            err_q <= ERR_CMD;
                        end
                    end
                    CMD_SAVE_EXIT: begin
                        if (save_go) begin
                            save_q <= 1'b1;
                            mode_q <= pend_foreign_q ? RSAC_ALIGN
                                                     : RSAC_MEAS;
                        end else begin
                            err_q <= ERR_CMD;
                        end
                    end
                    CMD_ABANDON: begin
                        if (mode_q == RSAC_SETUP && tail_zero) begin
                            mode_q <= RSAC_MEAS;
                        end else begin
                            err_q <= ERR_CMD;
                        end
                    end
                    CMD_ALIGN_IN: begin
                        if (align_ok && rest_zero) begin
                            mode_q <= RSAC_ALIGN;
                        end else begin
                            err_q <= ERR_CMD;
                        end
                    end
                    default: begin
                        err_q <= ERR_CMD;
                    end
                endcase
            end
        end
    end

    // Saved copy changes only on save-and-exit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sav_setup_q   <= ZERO16;
            sav_type_q    <= ZERO16;
            sav_turns_q   <= ZERO16;
            sav_fsc_q     <= 32'h0000_0000;
            sav_pre_q     <= 32'h0000_0000;
            sav_foreign_q <= 1'b0;
        end else if (save_go) begin
            sav_setup_q   <= pend_setup_q;
            sav_type_q    <= pend_type_q;
            sav_turns_q   <= pend_turns_q;
            sav_fsc_q     <= pend_fsc_q;
            sav_pre_q     <= pend_pre_q;
            sav_foreign_q <= pend_foreign_q;
        end
    end

    // Transducer fault flag, self clearing or latched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else if (fault_raw_i) begin
            fault_q <= 1'b1; // Set wins over clear
        end else if (mode_q == RSAC_ALIGN || !sav_setup_q[LATCH_BIT]) begin
            fault_q <= 1'b0;
        end else if (fault_clr_i) begin
            fault_q <= 1'b0;
        end
    end

    // Status words and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NWORDS; i++) begin
                net.in_word[i] <= ZERO16;
            end
            saving_o <= 1'b0;
            mode_o   <= ZERO16;
            fsc_o    <= 32'h0000_0000;
            preset_o <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < NWORDS; i++) begin
                net.in_word[i] <= ZERO16;
            end
            net.in_word[0] <= {ack_q, (mode_q == RSAC_ALIGN),
                               (mode_q == RSAC_SETUP), init_q,
                               fault_q, 4'h0,
                               sav_setup_q[GEAR_BIT] && sav_foreign_q,
                               sav_setup_q[LATCH_BIT],
                               sav_setup_q[DIR_BIT],
                               err_q};
            saving_o <= save_q;
            mode_o   <= {14'h0000, mode_q};
            fsc_o    <= sav_fsc_q;
            preset_o <= sav_pre_q;
        end
    end
endmodule // rsac_dev

/* File: rsac_host.sv */
// Host end: Wishbone registers drive the network command words
`timescale 1ns/1ps
module rsac_host
    import rsac_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    rsac_if.host             net
);
    logic [15:0] word_q [0:9];
    logic        hit_word;
    logic [3:0]  idx;

    assign idx      = adr_i[5:2];
    assign hit_word = (adr_i >= HR_WORD0) && (idx < 4'hA)
                      && (adr_i[7:6] == 2'b01);

    // Output words, written on the edge that samples ack high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NWORDS; i++) begin
                word_q[i] <= ZERO16;
            end
        end else if (cyc_i && stb_i && we_i && ack_o && hit_word) begin
            if (sel_i[0]) word_q[idx][7:0]  <= dat_i[7:0];
            if (sel_i[1]) word_q[idx][15:8] <= dat_i[15:8];
        end
    end

    // Drive the network words straight from registers
    always_comb begin
        for (int i = 0; i < NWORDS; i++) begin
            net.out_word[i] = word_q[i];
        end
    end

    // Single-cycle Wishbone answer and reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h0000_0000;
            if (cyc_i && stb_i && !ack_o && !we_i) begin
                if (hit_word) begin
                    dat_o <= {net.in_word[idx], word_q[idx]};
                end else if (adr_i == HR_STATUS) begin
                    dat_o <= {16'h0000, net.in_word[0]};
                end
            end
        end
    end
endmodule // rsac_host

/* File: rsac_asserts.sv */
// Concurrent checks on the network link between host and device ends
`timescale 1ns/1ps
module rsac_asserts
    import rsac_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] out_word [0:9],
    input wire logic [15:0] in_word  [0:9]
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic       strobe;
    logic       ack;
    logic       known;
    logic       rest_zero;
    logic [3:0] err;

    // Decoded views of the command and status words
    assign strobe    = out_word[0][STROBE_BIT];
    assign ack       = in_word[0][ST_ACK_BIT];
    assign err       = in_word[0][3:0];
    assign known     = out_word[0] inside {CMD_FOREIGN, CMD_SAVE_EXIT,
                       CMD_ABANDON, CMD_ALIGN_IN, CMD_SETUP_IN};
    assign rest_zero = (out_word[2] | out_word[3] | out_word[4] | out_word[5]
                      | out_word[6] | out_word[7] | out_word[8]
                      | out_word[9]) == ZERO16;

    AST_ACK_RISE: assert property ($rose(strobe) |-> ##[1:2] ack)
        else $error("strobe rise not acknowledged");
    AST_ACK_CAUSE: assert property ($rose(ack) |-> strobe)
        else $error("ack rose without strobe");
    AST_ACK_HOLD: assert property (ack && strobe |=> ack)
        else $error("ack dropped while strobe held");
    AST_ACK_FALL: assert property ($fell(strobe) |-> ##[1:2] !ack)
        else $error("ack not cleared after strobe clear");
    AST_ACK_IDLE: assert property (!strobe [*3] |-> !ack)
        else $error("ack high with strobe idle");
    AST_ERR_UNKNOWN: assert property ($rose(strobe) && !known
        |-> ##[1:2] (ack && err == ERR_CMD))
        else $error("unknown code not refused");
    AST_ALIGN_BADPW: assert property ($rose(strobe)
        && out_word[0] == CMD_ALIGN_IN && out_word[1] != ALIGN_PASSWD
        |-> ##[1:2] (ack && err == ERR_CMD))
        else $error("wrong password not refused");
    AST_ALIGN_OK: assert property ($rose(strobe)
        && out_word[0] == CMD_ALIGN_IN && out_word[1] == ALIGN_PASSWD
        && rest_zero && in_word[0][ST_INIT_BIT]
        |-> ##[1:2] (ack && err == ERR_NONE && in_word[0][ST_ALIGN_BIT]))
        else $error("alignment entry not accepted");
    AST_STATUS_RSVD: assert property (in_word[0][10:7] == 4'h0
        && in_word[0][3:1] == 3'h0)
        else $error("reserved status bits set");
endmodule // rsac_asserts

/* File: resolver_setup_align_cmds_tb.sv */
// Self-checking bench for host and device ends joined by the link
`timescale 1ns/1ps
module resolver_setup_align_cmds_tb;
    import rsac_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack;
    logic        fraw = 1'b0;
    logic        fclr = 1'b0;
    logic        cfgv = 1'b0;
    logic        saving;
    logic [15:0] mode;
    logic [15:0] st;
    logic [15:0] cst;
    logic [31:0] fsc;
    logic [31:0] preset;
    int          failures = 0;
    int          num_checks = 0;
    int          saves = 0;
    localparam logic [15:0] Z = ZERO16;

    rsac_if nif ();
    rsac_host u_rsac_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .net(nif));
    rsac_dev u_rsac_dev (.clk_i(clk_i), .rst_i(rst_i), .net(nif),
        .fault_raw_i(fraw), .fault_clr_i(fclr), .cfg_valid_i(cfgv),
        .saving_o(saving), .mode_o(mode), .fsc_o(fsc), .preset_o(preset));
    rsac_asserts u_rsac_asserts (.clk_i(clk_i), .rst_i(rst_i),
        .out_word(nif.out_word), .in_word(nif.in_word));

    // Clock and flash save pulse counter
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (saving === 1'b1) saves <= saves + 1;

    task automatic conclude();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (ack !== 1'b1) begin
            failures++;
            conclude();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wack(input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, HR_STATUS, 32'h0000_0000);
            st = rd[15:0];
            n++;
        end while (st[ST_ACK_BIT] !== v && n < 40);
        if (st[ST_ACK_BIT] !== v) begin
            failures++;
            conclude();
        end
    endtask

    // Words 1 to 9 first, command word with strobe last
    task automatic put(input logic [15:0] w0, w1, w2, w3, w4, w5, w6, w7);
        logic [15:0] w [0:9];
        w = '{w0, w1, w2, w3, w4, w5, w6, w7, Z, Z};
        for (int i = 1; i < 10; i++) wb(1'b1, HR_WORD0 + 8'(4 * i), {Z, w[i]});
        wb(1'b1, HR_WORD0, {Z, w0});
    endtask

    task automatic cmd(input logic [15:0] w0, w1, w2, w3, w4, w5, w6, w7);
        put(w0, w1, w2, w3, w4, w5, w6, w7);
        wack(1'b1);
        cst = st;
        wb(1'b1, HR_WORD0, 32'h0000_0000);
        wack(1'b0);
    endtask

    task automatic pulse_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic t_idle();
        wack(1'b0);
        chk(st, 16'h0000);
        wb(1'b1, 8'h80, 32'h0000_1234);
        wb(1'b0, 8'h80, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        cmd(CMD_ALIGN_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        chk(cst[3:0], ERR_CMD);
        chk(cst[ST_ALIGN_BIT], 1'b0);
        $display("idle and uninitialised test done");
    endtask

    task automatic t_refuse();
        put(16'hA123, Z, Z, Z, Z, Z, Z, Z);
        wack(1'b1);
        chk(st[3:0], ERR_CMD);
        put(CMD_SETUP_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        wack(1'b1);
        chk(st[ST_SETUP_BIT], 1'b0);
        wb(1'b1, HR_WORD0, 32'h0000_0000);
        wack(1'b0);
        chk(st[ST_ACK_BIT], 1'b0);
        cmd(CMD_ALIGN_IN, 16'h1297, Z, Z, Z, Z, Z, Z);
        chk(cst[3:0], ERR_CMD);
        chk(mode, 16'h0000);
        $display("refusal test done");
    endtask

    task automatic t_abandon_fault();
        cmd(CMD_SETUP_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        chk(cst[ST_SETUP_BIT], 1'b1);
        cmd(CMD_FOREIGN, 16'h0101, 16'h0040, 16'h0008, 16'h2345, 16'h0001,
            16'h00FF, Z);
        chk(cst[3:0], ERR_NONE);
        chk(fsc, 32'h0000_0000);
        cmd(CMD_ABANDON, Z, Z, Z, Z, Z, Z, Z);
        chk({cst[ST_SETUP_BIT], mode}, 17'h0_0000);
        chk(fsc, 32'h0000_0000);
        chk(saves, 0);
        fraw <= 1'b1;
        repeat (2) @(posedge clk_i);
        wack(1'b0);
        chk(st[ST_FAULT_BIT], 1'b1);
        fraw <= 1'b0;
        repeat (4) @(posedge clk_i);
        wack(1'b0);
        chk(st[ST_FAULT_BIT], 1'b0);
        $display("abandon and fault test done");
    endtask

    task automatic t_save();
        cmd(CMD_SETUP_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        cmd(CMD_FOREIGN, 16'h0103, 16'h0040, 16'h0008, 16'h2345, 16'h0001,
            16'h00FF, Z);
        cmd(CMD_SAVE_EXIT, Z, Z, Z, Z, Z, Z, Z);
        chk(cst[3:0], ERR_NONE);
        chk(cst[ST_ALIGN_BIT:ST_SETUP_BIT], 2'b10);
        chk(cst[6:4], 3'b111);
        chk(fsc, 32'h0001_2345);
        chk(preset, 32'h0000_00FF);
        chk(saves, 1);
        $display("save test done");
    endtask

    // Latch bit saved: self clearing in alignment, held in measurement
    task automatic t_latch();
        fraw <= 1'b1;
        repeat (2) @(posedge clk_i);
        fraw <= 1'b0;
        repeat (2) @(posedge clk_i);
        wack(1'b0);
        chk(st[ST_FAULT_BIT], 1'b0);
        cmd(CMD_SETUP_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        cmd(CMD_ABANDON, Z, Z, Z, Z, Z, Z, Z);
        chk(mode, 16'h0000);
        fraw <= 1'b1;
        repeat (2) @(posedge clk_i);
        fraw <= 1'b0;
        repeat (4) @(posedge clk_i);
        wack(1'b0);
        chk(st[ST_FAULT_BIT], 1'b1);
        fclr <= 1'b1;
        repeat (2) @(posedge clk_i);
        fclr <= 1'b0;
        wack(1'b0);
        chk(st[ST_FAULT_BIT], 1'b0);
        $display("fault latch test done");
    endtask

    task automatic t_reset_align();
        pulse_reset();
        cmd(CMD_SETUP_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        cmd(CMD_FOREIGN, 16'h0100, 16'h0080, 16'h0080, 16'h0002, Z, Z, Z);
        pulse_reset();
        wack(1'b0);
        chk({st[ST_SETUP_BIT], mode}, 17'h0_0000);
        cmd(CMD_ALIGN_IN, ALIGN_PASSWD, Z, Z, Z, Z, Z, Z);
        chk(cst[ST_ALIGN_BIT], 1'b1);
        chk(mode, 16'h0002);
        $display("reset and alignment test done");
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_idle();
        cfgv <= 1'b1;
        t_refuse();
        t_abandon_fault();
        t_save();
        t_latch();
        t_reset_align();
        conclude();
    end
endmodule // resolver_setup_align_cmds_tb
